// *** design/stpw_defines.vh ***
// Constants for the sample timing and pattern window configuration block.
// Assumes inclusion by bare name from each design file.
`ifndef STPW_DEFINES_VH
`define STPW_DEFINES_VH

// ==========================================================================
// Register indices; byte address is four times the index
`define STPW_IDX_RISE 6'h22
`define STPW_IDX_FALL 6'h23
`define STPW_IDX_BAND 6'h25
`define STPW_IDX_LOOP 6'h28
`define STPW_IDX_OFS_HI 6'h30
`define STPW_IDX_OFS_LO 6'h31
`define STPW_IDX_LEN_HI 6'h32
`define STPW_IDX_LEN_LO 6'h33

// ==========================================================================
// Field positions
`define STPW_IDX_MSB 5
`define STPW_IDX_LSB 0
`define STPW_CLKB_MSB 6
`define STPW_CLKB_LSB 4
`define STPW_DLLB_MSB 1
`define STPW_DLLB_LSB 0
`define STPW_LOOP_RST_BIT 0

// ==========================================================================
// Reset values
`define STPW_RISE_RST 6'h28
`define STPW_FALL_RST 6'h3C
`define STPW_CLKB_RST 3'h0
`define STPW_DLLB_RST 2'h2
`define STPW_BYTE_RST 8'h00

// ==========================================================================
// Band codes that software must not write
`define STPW_CLKB_BAD0 3'h6
`define STPW_CLKB_BAD1 3'h7
`define STPW_DLLB_BAD 2'h3

// ==========================================================================
// Grid and bus answers
`define STPW_PHASE_LAST 6'h3F
`define STPW_RESP_OK 2'h0
`define STPW_RESP_ERR 2'h2
`define STPW_COUNT_MAX 16'hFFFF

`endif

// *** design/stpw_strobe_gen.v ***
// Capture strobe on a 64-step grid per pixel period.
// Assumes one clk cycle per grid step; restart pulse from same domain.
`include "stpw_defines.vh"

module stpw_strobe_gen (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Control
  input wire restart_in,
  input wire [5:0] rise_idx_in,
  input wire [5:0] fall_idx_in,
  // Outputs
  output reg strobe_out,
  output reg pixel_tick_out,
  output wire [5:0] phase_out
);

  reg [5:0] phase_q;
  reg [5:0] phase_d;
  reg in_win;

  assign phase_out = phase_q;

  always @* begin
    if (restart_in || phase_q == `STPW_PHASE_LAST) begin
      phase_d = 6'h00;
    end else begin
      phase_d = phase_q + 6'h01;
    end
    // Wrapping window when the fall index precedes the rise index
    if (rise_idx_in <= fall_idx_in) begin
      in_win = (phase_d >= rise_idx_in) && (phase_d < fall_idx_in);
    end else begin
      in_win = (phase_d >= rise_idx_in) || (phase_d < fall_idx_in);
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_q <= 6'h00;
      strobe_out <= 1'b0;
      pixel_tick_out <= 1'b0;
    end else begin
      phase_q <= phase_d;
      strobe_out <= in_win;
      pixel_tick_out <= (phase_d == `STPW_PHASE_LAST);
    end
  end

endmodule // stpw_strobe_gen

// *** design/stpw_region_gen.v ***
// Valid pixel region counted from the line start edge.
// Assumes edge and tick pulses from the same clock domain.
`include "stpw_defines.vh"

module stpw_region_gen (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Timing
  input wire line_edge_in,
  input wire pixel_tick_in,
  // Configuration
  input wire [15:0] offset_in,
  input wire [15:0] length_in,
  // Outputs
  output reg region_valid_out,
  output reg [15:0] pixel_count_out
);

  wire [16:0] region_end;
  wire [16:0] count_ext;

  assign region_end = {1'b0, offset_in} + {1'b0, length_in};
  assign count_ext = {1'b0, pixel_count_out};

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pixel_count_out <= 16'h0000;
      region_valid_out <= 1'b0;
    end else begin
      if (line_edge_in) begin
        pixel_count_out <= 16'h0000;
      end else if (pixel_tick_in && pixel_count_out != `STPW_COUNT_MAX) begin
        // Saturates so a missing line start cannot wrap into a new region
        pixel_count_out <= pixel_count_out + 16'h0001;
      end
      region_valid_out <= !line_edge_in && (pixel_count_out >= offset_in) &&
                          (count_ext < region_end);
    end
  end

endmodule // stpw_region_gen

// *** design/stpw_cfg_top.v ***
// Sample timing and pattern window configuration registers.
// Assumes an Avalon-MM master on clk_in; the line start pin is asynchronous.
//
// Contract
// - Strobe rises at the 6-bit start index of the rise register.
// - Strobe falls at the 6-bit end index of the fall register.
// - Clock band field bits 6:4 selects band; codes 110 and 111 forbidden.
// - Loop band field bits 1:0 selects band; code 11 forbidden.
// - Writing one to loop config bit 0 resets loop, bit self-clears.
// - Region starts a 16-bit pixel count after the line start edge.
// - Region lasts a 16-bit pixel width held in two byte registers.
`include "stpw_defines.vh"

module stpw_cfg_top (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Avalon-MM slave
  input wire [7:0] address_in,
  input wire read_in,
  input wire write_in,
  input wire [31:0] writedata_in,
  input wire [3:0] byteenable_in,
  output wire [31:0] readdata_out,
  output wire waitrequest_out,
  output wire [1:0] response_out,
  // Line timing pin
  input wire line_start_pulse_in,
  // Front end controls
  output wire [2:0] input_pixel_clock_band_out,
  output wire [1:0] loop_band_out,
  output wire loop_reset_out,
  output wire strobe_out,
  output wire pixel_tick_out,
  output wire region_valid_out
);

  // ==========================================================================
  // Declarations
  reg ack_q;
  reg [31:0] rdata_q;
  reg [1:0] resp_q;
  reg [5:0] rise_q;
  reg [5:0] fall_q;
  reg [2:0] clkb_q;
  reg [1:0] dllb_q;
  reg loop_rst_q;
  reg [7:0] ofs_hi_q;
  reg [7:0] ofs_lo_q;
  reg [7:0] len_hi_q;
  reg [7:0] len_lo_q;
  reg [7:0] rbyte;
  reg hit;
  reg ls_meta_q;
  reg ls_sync_q;
  reg ls_prev_q;
  wire [5:0] idx;
  wire wr_take;
  wire wr_lane;
  wire [7:0] wbyte;
  wire [2:0] wclkb;
  wire [1:0] wdllb;
  wire line_edge;
  wire [5:0] phase_unused;
  wire [15:0] count_unused;

  assign idx = address_in[7:2];
  assign wbyte = writedata_in[7:0];
  assign wr_lane = byteenable_in[0];
  assign wclkb = wbyte[`STPW_CLKB_MSB:`STPW_CLKB_LSB];
  assign wdllb = wbyte[`STPW_DLLB_MSB:`STPW_DLLB_LSB];

  // ==========================================================================
  // Bus handshake: one wait cycle on every access
  assign waitrequest_out = (read_in || write_in) && !ack_q;
  assign wr_take = write_in && ack_q;
  assign readdata_out = rdata_q;
  assign response_out = resp_q;

  always @* begin
    hit = 1'b1;
    rbyte = `STPW_BYTE_RST;
    case (idx)
      `STPW_IDX_RISE: begin
        rbyte = {2'b00, rise_q};
      end
      `STPW_IDX_FALL: begin
        rbyte = {2'b00, fall_q};
      end
      `STPW_IDX_BAND: begin
        rbyte = {1'b0, clkb_q, 2'b00, dllb_q};
      end
      `STPW_IDX_LOOP: begin
        rbyte = {7'h00, loop_rst_q};
      end
      `STPW_IDX_OFS_HI: begin
        rbyte = ofs_hi_q;
      end
      `STPW_IDX_OFS_LO: begin
        rbyte = ofs_lo_q;
      end
      `STPW_IDX_LEN_HI: begin
        rbyte = len_hi_q;
      end
      `STPW_IDX_LEN_LO: begin
        rbyte = len_lo_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Read data captured in the wait cycle, so it stands when waitrequest drops
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      resp_q <= `STPW_RESP_OK;
    end else begin
      ack_q <= (read_in || write_in) && !ack_q;
      if ((read_in || write_in) && !ack_q) begin
        rdata_q <= read_in ? {24'h000000, rbyte} : 32'h00000000;
        resp_q <= hit ? `STPW_RESP_OK : `STPW_RESP_ERR;
      end
    end
  end

  // ==========================================================================
  // Configuration registers
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rise_q <= `STPW_RISE_RST;
      fall_q <= `STPW_FALL_RST;
      clkb_q <= `STPW_CLKB_RST;
      dllb_q <= `STPW_DLLB_RST;
      ofs_hi_q <= `STPW_BYTE_RST;
      ofs_lo_q <= `STPW_BYTE_RST;
      len_hi_q <= `STPW_BYTE_RST;
      len_lo_q <= `STPW_BYTE_RST;
    end else if (wr_take && wr_lane) begin
      case (idx)
        `STPW_IDX_RISE: begin
          rise_q <= wbyte[`STPW_IDX_MSB:`STPW_IDX_LSB];
        end
        `STPW_IDX_FALL: begin
          fall_q <= wbyte[`STPW_IDX_MSB:`STPW_IDX_LSB];
        end
        `STPW_IDX_BAND: begin
          if (wclkb != `STPW_CLKB_BAD0 && wclkb != `STPW_CLKB_BAD1) begin
            clkb_q <= wclkb;
          end
          if (wdllb != `STPW_DLLB_BAD) begin
            dllb_q <= wdllb;
          end
        end
        `STPW_IDX_OFS_HI: begin
          ofs_hi_q <= wbyte;
        end
        `STPW_IDX_OFS_LO: begin
          ofs_lo_q <= wbyte;
        end
        `STPW_IDX_LEN_HI: begin
          len_hi_q <= wbyte;
        end
        `STPW_IDX_LEN_LO: begin
          len_lo_q <= wbyte;
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      loop_rst_q <= 1'b0;
    end else begin
      loop_rst_q <= wr_take && wr_lane && (idx == `STPW_IDX_LOOP) &&
                    wbyte[`STPW_LOOP_RST_BIT];
    end
  end

  assign input_pixel_clock_band_out = clkb_q;
  assign loop_band_out = dllb_q;
  assign loop_reset_out = loop_rst_q;

  // ==========================================================================
  // Line start pin: two-stage synchroniser, then edge detect
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ls_meta_q <= 1'b0;
      ls_sync_q <= 1'b0;
      ls_prev_q <= 1'b0;
    end else begin
      ls_meta_q <= line_start_pulse_in;
      ls_sync_q <= ls_meta_q;
      ls_prev_q <= ls_sync_q;
    end
  end

  assign line_edge = ls_sync_q && !ls_prev_q;

  // ==========================================================================
  // Timing generators
  // Loop reset also realigns the strobe grid
  stpw_strobe_gen u_strobe (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .restart_in(loop_rst_q),
    .rise_idx_in(rise_q),
    .fall_idx_in(fall_q),
    .strobe_out(strobe_out),
    .pixel_tick_out(pixel_tick_out),
    .phase_out(phase_unused)
  );

  stpw_region_gen u_region (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .line_edge_in(line_edge),
    .pixel_tick_in(pixel_tick_out),
    .offset_in({ofs_hi_q, ofs_lo_q}),
    .length_in({len_hi_q, len_lo_q}),
    .region_valid_out(region_valid_out),
    .pixel_count_out(count_unused)
  );

endmodule // stpw_cfg_top

// *** tb/stpw_cfg_chk.sv ***
// Port checker for the configuration register block.
// Assumes it is bound onto stpw_cfg_top, one clock domain.
module stpw_cfg_chk (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Bus
  input wire [7:0] address_in,
  input wire read_in,
  input wire write_in,
  input wire [31:0] writedata_in,
  input wire [3:0] byteenable_in,
  input wire [31:0] readdata_out,
  input wire waitrequest_out,
  input wire [1:0] response_out,
  // Front end
  input wire line_start_pulse_in,
  input wire [2:0] input_pixel_clock_band_out,
  input wire [1:0] loop_band_out,
  input wire loop_reset_out,
  input wire strobe_out,
  input wire pixel_tick_out,
  input wire region_valid_out
);
  // ====
  // Taken transfers
  wire [5:0] idx = address_in[7:2];
  wire tk = !waitrequest_out && (read_in || write_in);
  wire wr_ok = tk && write_in && byteenable_in[0];
  wire loop_go = wr_ok && idx == 6'h28 && writedata_in[0];
  wire hit = idx inside {6'h22, 6'h23, 6'h25, 6'h28, 6'h30, 6'h31, 6'h32, 6'h33};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ====
  // Properties
  a_one_wait: assert property (waitrequest_out |=> !waitrequest_out)
    else $error("second wait cycle");
  a_idle_nowait: assert property (!(read_in || write_in) |-> !waitrequest_out)
    else $error("wait without request");
  a_unmapped_err: assert property (tk && read_in && !hit |-> response_out == 2'h2 && readdata_out == 32'h0)
    else $error("unmapped read answer");
  a_rsvd_zero: assert property (tk && read_in && hit |-> response_out == 2'h0 && readdata_out[31:8] == 24'h0)
    else $error("mapped read answer");
  a_band_legal: assert property (input_pixel_clock_band_out[2:1] != 2'h3 && loop_band_out != 2'h3)
    else $error("forbidden band code");
  a_band_cause: assert property ($changed({input_pixel_clock_band_out, loop_band_out}) |-> $past(wr_ok && idx == 6'h25))
    else $error("band change without write");
  a_loop_pulse: assert property (loop_go |=> loop_reset_out ##1 !loop_reset_out)
    else $error("loop reset pulse");
  a_loop_cause: assert property ($rose(loop_reset_out) |-> $past(loop_go))
    else $error("loop reset without write");
  a_tick_gap: assert property (pixel_tick_out |=> !pixel_tick_out [*8])
    else $error("ticks too close");
  c_loop: cover property (loop_go);
  c_strobe: cover property ($rose(strobe_out));
  c_region: cover property ($rose(region_valid_out));
endmodule // stpw_cfg_chk

bind stpw_cfg_top stpw_cfg_chk chk (.clk_in(clk_in), .reset_in(reset_in),
  .address_in(address_in), .read_in(read_in), .write_in(write_in),
  .writedata_in(writedata_in), .byteenable_in(byteenable_in),
  .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
  .response_out(response_out), .line_start_pulse_in(line_start_pulse_in),
  .input_pixel_clock_band_out(input_pixel_clock_band_out),
  .loop_band_out(loop_band_out), .loop_reset_out(loop_reset_out),
  .strobe_out(strobe_out), .pixel_tick_out(pixel_tick_out),
  .region_valid_out(region_valid_out));

// *** tb/tb_top.sv ***
// Self-checking bench for the configuration register block.
// Assumes an Avalon-MM slave and registered outputs on clk_in.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] address_in = 8'h00;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic [3:0] byteenable_in = 4'hF;
  logic line_start_pulse_in = 1'b0;
  wire [31:0] readdata_out;
  wire waitrequest_out;
  wire [1:0] response_out;
  wire [2:0] input_pixel_clock_band_out;
  wire [1:0] loop_band_out;
  wire loop_reset_out;
  wire strobe_out;
  wire pixel_tick_out;
  wire region_valid_out;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] rdat;
  logic [1:0] rsp;
  logic [7:0] adr [8] = '{8'h88, 8'h8C, 8'h94, 8'hA0, 8'hC0, 8'hC4, 8'hC8, 8'hCC};
  logic [7:0] msk [8] = '{8'h3F, 8'h3F, 8'h73, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] cur [8] = '{8'h28, 8'h3C, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #50 clk_in = ~clk_in;
  stpw_cfg_top dut (.clk_in(clk_in), .reset_in(reset_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(byteenable_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .response_out(response_out),
    .line_start_pulse_in(line_start_pulse_in),
    .input_pixel_clock_band_out(input_pixel_clock_band_out),
    .loop_band_out(loop_band_out), .loop_reset_out(loop_reset_out),
    .strobe_out(strobe_out), .pixel_tick_out(pixel_tick_out),
    .region_valid_out(region_valid_out));
  // ====
  // Shared tasks
  task automatic complete_run();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    read_in <= !wr;
    write_in <= wr;
    address_in <= a;
    writedata_in <= d;
    @(posedge clk_in);
    while (waitrequest_out !== 1'b0) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        complete_run();
      end
      @(posedge clk_in);
    end
    rdat = readdata_out;
    rsp = response_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rdchk(input int i);
    bus(1'b0, adr[i], 32'h0);
    chk(rdat, {24'h0, cur[i]});
    chk(rsp, 2'h0);
  endtask
  // Illegal band codes keep the previous field
  function automatic logic [7:0] nxt(int i, logic [7:0] o, logic [7:0] d);
    nxt = d & msk[i];
    if (i == 3) nxt = 8'h00;
    if (i == 2 && d[6:5] == 2'h3) nxt[6:4] = o[6:4];
    if (i == 2 && d[1:0] == 2'h3) nxt[1:0] = o[1:0];
  endfunction
  task automatic wrx(input int i, input logic [7:0] d);
    bus(1'b1, adr[i], {$urandom, d} >> 0);
    cur[i] = nxt(i, cur[i], d);
  endtask
  task automatic cnt(input bit s, input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge clk_in);
      h += s ? region_valid_out : strobe_out;
    end
  endtask
  // ====
  // Main sequence
  initial begin
    int h;
    int t [4][3] = '{'{10, 20, 10}, '{60, 4, 8}, '{30, 30, 0}, '{0, 63, 63}};
    // Offset of at least one pixel: the pixel under way at line start is partial
    int r [3][3] = '{'{3, 5, 5}, '{1, 2, 2}, '{2, 0, 0}};
    void'($urandom(76796));
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    for (int i = 0; i < 8; i++) rdchk(i);
    for (int i = 0; i < 8; i++) wrx(i, cur[i]);
    for (int k = 0; k < 40; k++) begin
      h = $urandom_range(7);
      wrx(h, $urandom);
      rdchk(h);
    end
    for (int c = 0; c < 8; c++) begin
      wrx(2, {1'b0, c[2:0], 2'h0, c[1:0]});
      rdchk(2);
      chk(input_pixel_clock_band_out, cur[2][6:4]);
      chk(loop_band_out, cur[2][1:0]);
    end
    byteenable_in <= 4'h0;
    bus(1'b1, adr[4], 32'hA5);
    byteenable_in <= 4'hF;
    rdchk(4);
    bus(1'b0, 8'h00, 32'h0);
    chk(rsp, 2'h2);
    chk(rdat, 32'h0);
    wrx(3, 8'h01);
    rdchk(3);
    for (int k = 0; k < 4; k++) begin
      wrx(0, t[k][0]);
      wrx(1, t[k][1]);
      repeat (70) @(posedge clk_in);
      cnt(1'b0, 64, h);
      chk(h, t[k][2]);
    end
    wrx(4, 8'h00);
    wrx(6, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wrx(5, r[k][0]);
      wrx(7, r[k][1]);
      repeat (1000) @(posedge clk_in);
      line_start_pulse_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      line_start_pulse_in <= 1'b0;
      cnt(1'b1, 14 * 64, h);
      chk(h, r[k][2] * 64);
    end
    complete_run();
  end
endmodule // tb_top
